// [rtl/adc_cal_pkg.sv]
package adc_cal_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] CAL_CONTROL_OFS = 8'h00;
    localparam logic [7:0] CONV_CONFIG_A_OFS = 8'h04;
    localparam logic [7:0] CONV_CONFIG_B_OFS = 8'h08;
    localparam logic [7:0] OFFSET_COEF_HIGH_OFS = 8'h0C;
    localparam logic [7:0] OFFSET_COEF_LOW_OFS = 8'h10;
    localparam logic [7:0] GAIN_COEF_HIGH_OFS = 8'h14;
    localparam logic [7:0] GAIN_COEF_LOW_OFS = 8'h18;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h1C;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h20;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h24;

    // cal_control_reg fields
    localparam int BUSY_BIT = 7;
    localparam int AVG_LSB = 4;
    localparam int MODE_BIT = 1;
    localparam int START_BIT = 0;
    localparam logic [7:0] CMD_OFFSET_CAL = 8'h25;
    localparam logic [7:0] CMD_GAIN_CAL = 8'h27;

    // conv_config_a_reg fields
    localparam int DIV_LSB = 4;
    localparam int ACQ_LSB = 2;

    // channel_select_field codes of the internal calibration sources
    localparam logic [3:0] CH_GND = 4'hB;
    localparam logic [3:0] CH_REF = 4'hC;

    // average_count per code 0..3
    localparam logic [5:0] AVG_C0 = 6'h0F;
    localparam logic [5:0] AVG_C1 = 6'h01;
    localparam logic [5:0] AVG_C2 = 6'h1F;
    localparam logic [5:0] AVG_C3 = 6'h3F;
    // converter_clock divide per code 0..3
    localparam logic [5:0] DIV_C0 = 6'h08;
    localparam logic [5:0] DIV_C1 = 6'h04;
    localparam logic [5:0] DIV_C2 = 6'h10;
    localparam logic [5:0] DIV_C3 = 6'h20;
    // Conversion length is this base plus acquisition_clocks (code + 1)
    localparam logic [4:0] CONV_BASE_CLKS = 5'h10;
    localparam int CAL_BITS = 14;
    localparam logic [11:0] RESULT_FULL = 12'hFFF;

    // Reset values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [15:0] COEF_RESET = 16'h2000;

    // Interrupt status bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_REFUSED_BIT = 1;
    localparam int IRQ_W = 2;

    typedef enum logic {
        ST_IDLE,
        ST_CONV
    } cal_state_e;

    typedef struct packed {
        logic start;
        logic [3:0] channel;
        logic gnd_sel;
        logic ref_sel;
        logic gain_mode;
        logic [15:0] trial_coef;
    } conv_req_s;

endpackage

// [rtl/adc_calibration_sequencer.sv]
// Overview of operation
// - Bit 1 of calibration control plus channel field choose the calibration.
// - Device offset calibration samples internal ground on channel code 1011.
// - Device gain calibration samples internal reference on channel code 1100.
// - Writing 25H starts offset calibration, 31 samples averaged per bit.
// - Writing 27H starts gain calibration with the same averaging.
// - Cycle lasts 14 x averages x (16 + acquisition) converter clocks.
// - Busy bit 7 rises at start and stays high until cycle end.
// - Each coefficient is 14 bits, six high bits and eight low.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
module adc_calibration_sequencer #(
    parameter int coef_w = 14
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] conv_result,
    output adc_cal_pkg::conv_req_s conv_req,
    output logic irq
);

    if (coef_w < 9 || coef_w > 15) begin : g_bad_width
        $error("coef_w must lie between 9 and 15");
    end

    localparam int HI_W = coef_w - 8;

    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic irq_q;
    adc_cal_pkg::conv_req_s conv_req_q;
    adc_cal_pkg::cal_state_e state_q;
    logic busy_q;
    logic [6:1] ctl_q;
    logic [7:0] cfg_a_q;
    logic [7:0] cfg_b_q;
    logic [coef_w-1:0] off_coef_q;
    logic [coef_w-1:0] gain_coef_q;
    logic [5:0] div_q;
    logic [5:0] div_cnt_q;
    logic [4:0] conv_len_q;
    logic [4:0] ccnt_q;
    logic [5:0] navg_q;
    logic [5:0] samp_q;
    logic [17:0] acc_q;
    logic [3:0] bit_q;
    logic [adc_cal_pkg::IRQ_W-1:0] irq_stat_q;
    logic [adc_cal_pkg::IRQ_W-1:0] irq_en_q;

    function automatic logic [5:0] avg_of(input logic [1:0] code);
        case (code)
            2'h0: avg_of = adc_cal_pkg::AVG_C0;
            2'h1: avg_of = adc_cal_pkg::AVG_C1;
            2'h2: avg_of = adc_cal_pkg::AVG_C2;
            default: avg_of = adc_cal_pkg::AVG_C3;
        endcase
    endfunction

    function automatic logic [5:0] div_of(input logic [1:0] code);
        case (code)
            2'h0: div_of = adc_cal_pkg::DIV_C0;
            2'h1: div_of = adc_cal_pkg::DIV_C1;
            2'h2: div_of = adc_cal_pkg::DIV_C2;
            default: div_of = adc_cal_pkg::DIV_C3;
        endcase
    endfunction

    // APB decode; the answer comes one cycle into the access phase
    wire acc_ph = psel & penable;
    wire xfer_done = acc_ph & pready_q;
    wire answer = acc_ph & ~pready_q;
    wire wr_ev = xfer_done & pwrite & pstrb[0];
    wire hit_cal = paddr == adc_cal_pkg::CAL_CONTROL_OFS;
    wire hit_cfg_a = paddr == adc_cal_pkg::CONV_CONFIG_A_OFS;
    wire hit_cfg_b = paddr == adc_cal_pkg::CONV_CONFIG_B_OFS;
    wire hit_ofs_h = paddr == adc_cal_pkg::OFFSET_COEF_HIGH_OFS;
    wire hit_ofs_l = paddr == adc_cal_pkg::OFFSET_COEF_LOW_OFS;
    wire hit_gan_h = paddr == adc_cal_pkg::GAIN_COEF_HIGH_OFS;
    wire hit_gan_l = paddr == adc_cal_pkg::GAIN_COEF_LOW_OFS;
    wire hit_stat = paddr == adc_cal_pkg::IRQ_STATUS_OFS;
    wire hit_clr = paddr == adc_cal_pkg::IRQ_CLEAR_OFS;
    wire hit_en = paddr == adc_cal_pkg::IRQ_ENABLE_OFS;
    wire mapped = |{hit_cal, hit_cfg_a, hit_cfg_b, hit_ofs_h, hit_ofs_l,
        hit_gan_h, hit_gan_l, hit_stat, hit_clr, hit_en};

    // Coefficients stay software-writable only while no cycle owns them
    wire sw_coef_wr = wr_ev & ~busy_q;
    wire start_wr = wr_ev & hit_cal & pwdata[adc_cal_pkg::START_BIT]
        & ~busy_q;
    wire refused = wr_ev & hit_cal & busy_q;

    wire [7:0] cal_rd = {busy_q, ctl_q, 1'b0};
    wire [7:0] rd_byte =
        hit_cal ? cal_rd :
        hit_cfg_a ? cfg_a_q :
        hit_cfg_b ? cfg_b_q :
        hit_ofs_h ? 8'(off_coef_q[coef_w-1:8]) :
        hit_ofs_l ? off_coef_q[7:0] :
        hit_gan_h ? 8'(gain_coef_q[coef_w-1:8]) :
        hit_gan_l ? gain_coef_q[7:0] :
        hit_stat ? 8'(irq_stat_q) :
        hit_en ? 8'(irq_en_q) : 8'h00;

    // Calibration timing
    wire tick = state_q == adc_cal_pkg::ST_CONV
        && div_cnt_q == div_q - 6'h01;
    wire conv_end = tick && ccnt_q == conv_len_q - 5'h01;
    wire bit_end = conv_end && samp_q == navg_q - 6'h01;
    wire cal_end = bit_end && bit_q == 4'h0;

    wire [17:0] acc_sum = acc_q + 18'(conv_result);
    wire [17:0] gain_full = {12'h000, navg_q} * {6'h00,
        adc_cal_pkg::RESULT_FULL};
    // Offset: keep the trial bit while residual reads above zero;
    // gain: keep it while the reference still reads short of full scale
    wire keep = conv_req_q.gain_mode ? acc_sum < gain_full
        : acc_sum != 18'h0;
    wire [coef_w-1:0] trial = conv_req_q.trial_coef[coef_w-1:0];
    wire [coef_w-1:0] bit_mask = coef_w'(1) << bit_q;
    wire [coef_w-1:0] coef_res = keep ? trial : trial & ~bit_mask;
    wire [coef_w-1:0] next_trial = coef_res | (bit_mask >> 1);

    wire [3:0] chan_sel = cfg_b_q[3:0];
    wire gain_sel = pwdata[adc_cal_pkg::MODE_BIT];
    wire [1:0] div_code = cfg_a_q[adc_cal_pkg::DIV_LSB +: 2];
    wire [1:0] acq_code = cfg_a_q[adc_cal_pkg::ACQ_LSB +: 2];
    wire [1:0] avg_code = pwdata[adc_cal_pkg::AVG_LSB +: 2];

    // Interrupt: set wins over a clear in the same cycle
    wire [adc_cal_pkg::IRQ_W-1:0] irq_set = {refused, cal_end};
    wire [adc_cal_pkg::IRQ_W-1:0] irq_clr = (wr_ev & hit_clr)
        ? pwdata[adc_cal_pkg::IRQ_W-1:0] : '0;
    wire [adc_cal_pkg::IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~irq_clr)
        | irq_set;
    wire [adc_cal_pkg::IRQ_W-1:0] irq_en_d = (wr_ev & hit_en)
        ? pwdata[adc_cal_pkg::IRQ_W-1:0] : irq_en_q;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign conv_req = conv_req_q;
    assign irq = irq_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= answer;
            prdata_q <= answer && !pwrite ? {24'h000000, rd_byte}
                : 32'h0000_0000;
            pslverr_q <= answer & ~mapped;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_stat_q <= '0;
            irq_en_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_en_q <= irq_en_d;
            irq_q <= |(irq_stat_d & irq_en_d);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_q <= '0;
            cfg_a_q <= adc_cal_pkg::CONFIG_RESET;
            cfg_b_q <= adc_cal_pkg::CONFIG_RESET;
        end else begin
            if (wr_ev && hit_cal && !busy_q) begin
                ctl_q <= pwdata[6:1];
            end
            if (wr_ev && hit_cfg_a) begin
                cfg_a_q <= pwdata[7:0];
            end
            if (wr_ev && hit_cfg_b) begin
                cfg_b_q <= pwdata[7:0];
            end
        end
    end

    // Coefficient store: a finishing cycle has priority over software
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            off_coef_q <= adc_cal_pkg::COEF_RESET[coef_w-1:0];
            gain_coef_q <= adc_cal_pkg::COEF_RESET[coef_w-1:0];
        end else if (cal_end) begin
            if (conv_req_q.gain_mode) begin
                gain_coef_q <= coef_res;
            end else begin
                off_coef_q <= coef_res;
            end
        end else if (sw_coef_wr) begin
            if (hit_ofs_h) begin
                off_coef_q[coef_w-1:8] <= pwdata[HI_W-1:0];
            end
            if (hit_ofs_l) begin
                off_coef_q[7:0] <= pwdata[7:0];
            end
            if (hit_gan_h) begin
                gain_coef_q[coef_w-1:8] <= pwdata[HI_W-1:0];
            end
            if (hit_gan_l) begin
                gain_coef_q[7:0] <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= adc_cal_pkg::ST_IDLE;
            busy_q <= 1'b0;
            conv_req_q <= '0;
            div_q <= adc_cal_pkg::DIV_C0;
            div_cnt_q <= 6'h00;
            conv_len_q <= adc_cal_pkg::CONV_BASE_CLKS;
            ccnt_q <= 5'h00;
            navg_q <= adc_cal_pkg::AVG_C0;
            samp_q <= 6'h00;
            acc_q <= 18'h00000;
            bit_q <= 4'h0;
        end else begin
            conv_req_q.start <= 1'b0;
            unique case (state_q)
                adc_cal_pkg::ST_IDLE: begin
                    if (start_wr) begin
                        state_q <= adc_cal_pkg::ST_CONV;
                        busy_q <= 1'b1;
                        conv_req_q.start <= 1'b1;
                        conv_req_q.channel <= chan_sel;
                        conv_req_q.gnd_sel <=
                            chan_sel == adc_cal_pkg::CH_GND;
                        conv_req_q.ref_sel <=
                            chan_sel == adc_cal_pkg::CH_REF;
                        conv_req_q.gain_mode <= gain_sel;
                        conv_req_q.trial_coef <=
                            16'(coef_w'(1) << (coef_w - 1));
                        navg_q <= avg_of(avg_code);
                        div_q <= div_of(div_code);
                        conv_len_q <= adc_cal_pkg::CONV_BASE_CLKS
                            + 5'(acq_code) + 5'h01;
                        div_cnt_q <= 6'h00;
                        ccnt_q <= 5'h00;
                        samp_q <= 6'h00;
                        acc_q <= 18'h00000;
                        bit_q <= 4'(coef_w - 1);
                    end
                end
                adc_cal_pkg::ST_CONV: begin
                    div_cnt_q <= tick ? 6'h00 : div_cnt_q + 6'h01;
                    if (tick) begin
                        ccnt_q <= conv_end ? 5'h00 : ccnt_q + 5'h01;
                    end
                    if (conv_end) begin
                        samp_q <= bit_end ? 6'h00 : samp_q + 6'h01;
                        acc_q <= bit_end ? 18'h00000 : acc_sum;
                        conv_req_q.start <= ~cal_end;
                    end
                    if (bit_end) begin
                        conv_req_q.trial_coef <= 16'(next_trial);
                        bit_q <= bit_q - 4'h1;
                    end
                    if (cal_end) begin
                        state_q <= adc_cal_pkg::ST_IDLE;
                        busy_q <= 1'b0;
                        conv_req_q.trial_coef <= 16'(coef_res);
                    end
                end
            endcase
        end
    end

    // Helper for checking the cycle length
    logic [31:0] busy_cyc_q;
    wire [31:0] exp_cyc = 32'(coef_w) * 32'(navg_q)
        * 32'(conv_len_q) * 32'(div_q);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_cyc_q <= 32'h0000_0000;
        end else begin
            busy_cyc_q <= busy_q ? busy_cyc_q + 32'h0000_0001
                : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_mode_select: assert property (
        start_wr |=> conv_req_q.gain_mode == $past(gain_sel)
            && conv_req_q.channel == $past(chan_sel))
        else $error("calibration mode not taken from control and channel");
    a_ground_pick: assert property (
        busy_q && conv_req_q.channel == adc_cal_pkg::CH_GND
            |-> conv_req_q.gnd_sel && !conv_req_q.ref_sel)
        else $error("ground source not selected for code 1011");
    a_reference_pick: assert property (
        busy_q && conv_req_q.channel == adc_cal_pkg::CH_REF
            |-> conv_req_q.ref_sel && !conv_req_q.gnd_sel)
        else $error("reference source not selected for code 1100");
    a_offset_start: assert property (
        start_wr && pwdata[7:0] == adc_cal_pkg::CMD_OFFSET_CAL
            |=> busy_q && !conv_req_q.gain_mode
            && navg_q == adc_cal_pkg::AVG_C2)
        else $error("offset command did not start a 31-sample cycle");
    a_gain_start: assert property (
        start_wr && pwdata[7:0] == adc_cal_pkg::CMD_GAIN_CAL
            |=> busy_q && conv_req_q.gain_mode
            && navg_q == adc_cal_pkg::AVG_C2)
        else $error("gain command did not start a 31-sample cycle");
    a_cycle_length: assert property (
        $fell(busy_q) |-> busy_cyc_q == exp_cyc)
        else $error("calibration cycle length is wrong");
    a_busy_rise: assert property (
        $rose(busy_q) |-> $past(start_wr) && conv_req_q.start)
        else $error("busy rose without a calibration start");
    a_busy_fall: assert property (
        busy_q && !cal_end |=> busy_q)
        else $error("busy dropped before the cycle ended");
    a_high_split: assert property (
        answer && !pwrite && (hit_ofs_h || hit_gan_h)
            |=> prdata_q[31:HI_W] == '0)
        else $error("coefficient high register wider than its field");
    a_offset_store: assert property (
        cal_end && !conv_req_q.gain_mode
            |=> off_coef_q == $past(coef_res)
            && gain_coef_q == $past(gain_coef_q))
        else $error("offset coefficient not stored at cycle end");
    a_gain_store: assert property (
        cal_end && conv_req_q.gain_mode
            |=> gain_coef_q == $past(coef_res)
            && off_coef_q == $past(off_coef_q))
        else $error("gain coefficient not stored at cycle end");

    c_offset_done: cover property (
        cal_end && !conv_req_q.gain_mode);
    c_gain_done: cover property (
        cal_end && conv_req_q.gain_mode);
    c_refused_start: cover property (refused);
    c_irq_raised: cover property ($rose(irq_q));

endmodule

// [tb/adc_calibration_sequencer_bench.sv]
`timescale 1ns/1ps
module adc_calibration_sequencer_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [11:0] conv_result = 12'h000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    adc_cal_pkg::conv_req_s conv_req;
    logic irq;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int cmp_count = 0;

    always #5 clk_sys = ~clk_sys;

    adc_calibration_sequencer i_adc_calibration_sequencer (
        .clk_sys(clk_sys),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .conv_result(conv_result),
        .conv_req(conv_req),
        .irq(irq)
    );

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Idle edge first, so a released strobe is never raised in the same step
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            fails++;
            print_verdict();
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic t_reset();
        rdchk(adc_cal_pkg::CAL_CONTROL_OFS, 32'h00);
        rdchk(adc_cal_pkg::CONV_CONFIG_A_OFS, 32'h00);
        rdchk(adc_cal_pkg::CONV_CONFIG_B_OFS, 32'h00);
        rdchk(adc_cal_pkg::OFFSET_COEF_HIGH_OFS, 32'h20);
        rdchk(adc_cal_pkg::OFFSET_COEF_LOW_OFS, 32'h00);
        rdchk(adc_cal_pkg::GAIN_COEF_HIGH_OFS, 32'h20);
        rdchk(adc_cal_pkg::GAIN_COEF_LOW_OFS, 32'h00);
        apb(1'b0, 8'h28, 32'h0);
        chk({31'h0, err}, 32'h1);
        // A write without lane 0 must leave the register alone
        pstrb <= 4'hE;
        apb(1'b1, adc_cal_pkg::CONV_CONFIG_B_OFS, 32'hFF);
        pstrb <= 4'hF;
        rdchk(adc_cal_pkg::CONV_CONFIG_B_OFS, 32'h00);
        apb(1'b1, adc_cal_pkg::IRQ_STATUS_OFS, 32'hFF);
        rdchk(adc_cal_pkg::IRQ_STATUS_OFS, 32'h00);
        chk({31'h0, irq}, 32'h0);
        $display("test reset done");
    endtask

    // Full 31-average offset run, timed by the done interrupt
    task automatic t_offset();
        int cyc;
        int starts;
        apb(1'b1, adc_cal_pkg::CONV_CONFIG_A_OFS, 32'h10);
        apb(1'b1, adc_cal_pkg::CONV_CONFIG_B_OFS, 32'h0B);
        apb(1'b1, adc_cal_pkg::IRQ_ENABLE_OFS, 32'h01);
        apb(1'b1, adc_cal_pkg::CAL_CONTROL_OFS, 32'h25);
        starts = 0;
        for (cyc = 1; cyc < 40000; cyc++) begin
            @(posedge clk_sys);
            if (cyc == 1) begin
                chk({31'h0, conv_req.gnd_sel}, 32'h1);
                chk({31'h0, conv_req.gain_mode}, 32'h0);
                chk({28'h0, conv_req.channel}, 32'hB);
                chk({16'h0, conv_req.trial_coef}, 32'h2000);
            end
            if (conv_req.start === 1'b1) starts++;
            if (irq === 1'b1) break;
        end
        if (cyc == 40000) begin
            fails++;
            print_verdict();
        end
        // Busy length plus the edge at which the done interrupt shows
        chk(cyc, 14 * 31 * (16 + 1) * 4 + 1);
        chk(starts, 14 * 31);
        rdchk(adc_cal_pkg::CAL_CONTROL_OFS, 32'h24);
        rdchk(adc_cal_pkg::IRQ_ENABLE_OFS, 32'h01);
        rdchk(adc_cal_pkg::OFFSET_COEF_HIGH_OFS, 32'h00);
        rdchk(adc_cal_pkg::OFFSET_COEF_LOW_OFS, 32'h00);
        rdchk(adc_cal_pkg::GAIN_COEF_HIGH_OFS, 32'h20);
        apb(1'b1, adc_cal_pkg::IRQ_CLEAR_OFS, 32'h03);
        rdchk(adc_cal_pkg::IRQ_STATUS_OFS, 32'h00);
        chk({31'h0, irq}, 32'h0);
        $display("test offset done");
    endtask

    // Full gain run polled by software, with a refused restart meanwhile
    task automatic t_gain();
        int n;
        apb(1'b1, adc_cal_pkg::CONV_CONFIG_B_OFS, 32'h0C);
        apb(1'b1, adc_cal_pkg::IRQ_ENABLE_OFS, 32'h02);
        apb(1'b1, adc_cal_pkg::CAL_CONTROL_OFS, 32'h27);
        // The request launches on the taking edge; look one edge later
        @(posedge clk_sys);
        chk({31'h0, conv_req.ref_sel}, 32'h1);
        chk({31'h0, conv_req.gnd_sel}, 32'h0);
        chk({31'h0, conv_req.gain_mode}, 32'h1);
        rdchk(adc_cal_pkg::CAL_CONTROL_OFS, 32'hA6);
        apb(1'b1, adc_cal_pkg::CAL_CONTROL_OFS, 32'h25);
        rdchk(adc_cal_pkg::IRQ_STATUS_OFS, 32'h02);
        chk({31'h0, irq}, 32'h1);
        for (n = 0; n < 8000; n++) begin
            apb(1'b0, adc_cal_pkg::CAL_CONTROL_OFS, 32'h0);
            if (rd[7] === 1'b0) break;
        end
        if (n == 8000) begin
            fails++;
            print_verdict();
        end
        chk(rd, 32'h26);
        rdchk(adc_cal_pkg::GAIN_COEF_HIGH_OFS, 32'h3F);
        rdchk(adc_cal_pkg::GAIN_COEF_LOW_OFS, 32'hFF);
        rdchk(adc_cal_pkg::OFFSET_COEF_HIGH_OFS, 32'h00);
        rdchk(adc_cal_pkg::IRQ_STATUS_OFS, 32'h03);
        $display("test gain done");
    endtask

    // System calibration on external channels at the recommended clocks
    task automatic t_system();
        int cyc;
        int n;
        apb(1'b1, adc_cal_pkg::IRQ_CLEAR_OFS, 32'h03);
        apb(1'b1, adc_cal_pkg::IRQ_ENABLE_OFS, 32'h01);
        apb(1'b1, adc_cal_pkg::CONV_CONFIG_A_OFS, 32'hAC);
        apb(1'b1, adc_cal_pkg::CONV_CONFIG_B_OFS, 32'h00);
        // A residual above zero keeps every offset trial bit
        conv_result <= 12'h001;
        apb(1'b1, adc_cal_pkg::CAL_CONTROL_OFS, 32'h15);
        for (cyc = 1; cyc < 6000; cyc++) begin
            @(posedge clk_sys);
            if (cyc == 1) begin
                chk({28'h0, conv_req.channel}, 32'h0);
                chk({31'h0, conv_req.gnd_sel}, 32'h0);
                chk({31'h0, conv_req.ref_sel}, 32'h0);
            end
            if (irq === 1'b1) break;
        end
        if (cyc == 6000) begin
            fails++;
            print_verdict();
        end
        chk(cyc, 14 * 1 * (16 + 4) * 16 + 1);
        rdchk(adc_cal_pkg::OFFSET_COEF_HIGH_OFS, 32'h3F);
        rdchk(adc_cal_pkg::OFFSET_COEF_LOW_OFS, 32'hFF);
        apb(1'b1, adc_cal_pkg::CONV_CONFIG_B_OFS, 32'h01);
        // Full scale on the reference drops every gain trial bit
        conv_result <= 12'hFFF;
        apb(1'b1, adc_cal_pkg::CAL_CONTROL_OFS, 32'h17);
        for (n = 0; n < 2000; n++) begin
            apb(1'b0, adc_cal_pkg::CAL_CONTROL_OFS, 32'h0);
            if (rd[7] === 1'b0) break;
        end
        if (n == 2000) begin
            fails++;
            print_verdict();
        end
        chk(rd, 32'h16);
        rdchk(adc_cal_pkg::GAIN_COEF_HIGH_OFS, 32'h00);
        rdchk(adc_cal_pkg::GAIN_COEF_LOW_OFS, 32'h00);
        rdchk(adc_cal_pkg::OFFSET_COEF_LOW_OFS, 32'hFF);
        $display("test system done");
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_offset();
        t_gain();
        t_system();
        print_verdict();
    end
endmodule
